/* hdl/pcm_clk_div.sv */
// Processor clock divider producing a one-cycle enable every 2**shift cycles.
// Assumes the requester holds shift_req; it is adopted only at a boundary.
`timescale 1ns/1ns
module pcm_clk_div
    import pcm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    pcm_div_if.div dif
);
    logic [PCM_CNT_W-1:0] cnt_reg;
    logic [PCM_SHIFT_W-1:0] shift_reg;
    logic tick_reg;

    assign dif.shift_cur = shift_reg;
    assign dif.tick = tick_reg;

    // ==========================================================
    // Count down; ratio changes only on wrap so no pulse is cut short
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            shift_reg <= '0;
        end else if (cnt_reg == '0) begin
            shift_reg <= dif.shift_req;
            cnt_reg <= PCM_CNT_W'((1 << dif.shift_req) - 1);
        end else begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (cnt_reg == '0);
        end
    end

    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_ratio_at_boundary;
        !$stable(shift_reg) |-> $past(cnt_reg == '0);
    endproperty
    a_ratio_at_boundary: assert property (p_ratio_at_boundary)
        else $error("divide ratio changed between boundaries");

    sequence s_eight_gap;
        !tick_reg [*7] ##1 tick_reg;
    endsequence
    property p_div8_spacing;
        tick_reg && shift_reg == 3'h3 && dif.shift_req == 3'h3 |=> s_eight_gap;
    endproperty
    a_div8_spacing: assert property (p_div8_spacing)
        else $error("divide by eight period wrong");
endmodule : pcm_clk_div

/* hdl/pcm_power_mgr.sv */
// Processor clock divide and HALT-driven sleep control.
// Assumes host cycle signals on CLK; MASKABLE_INTERRUPT_REQUEST and NMI arrive from pins.
`timescale 1ns/1ns
module pcm_power_mgr
    import pcm_pkg::*;
#(
    parameter logic [PCM_SHIFT_W-1:0] SLEEP_SHIFT = PCM_SLEEP_SHIFT_DEF
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_RVALID,
    input wire logic HALT_FETCH,
    input wire logic MASKABLE_INTERRUPT_REQUEST,
    input wire logic NMI,
    input wire logic DMA_CYCLE,
    input wire logic REFRESH_CYCLE,
    output logic PROC_CLK_EN,
    output logic SLEEP_ACTIVE
);
    localparam int NSYNC = 2;

    logic [7:0] index_reg;
    logic [7:0] cfg_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic sleep_reg;
    logic first_reg;
    pcm_state_e state_reg;
    pcm_state_e state_next;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] wake_lvl;
    logic wake;
    logic bus_busy;
    logic data_sel;
    logic [PCM_SHIFT_W-1:0] sleep_shift;
    logic [PCM_SHIFT_W-1:0] shift_req;

    pcm_div_if dif ();

    pcm_clk_div u_div (
        .clk(CLK),
        .rst_b(RST_B),
        .dif(dif.div)
    );

    // ==========================================================
    // Pin synchronisers; a change counts when stages two and three agree
    assign pin_raw = {NMI, MASKABLE_INTERRUPT_REQUEST};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign wake_lvl[i] = lvl_reg;
        end
    endgenerate

    assign wake = |wake_lvl;
    assign bus_busy = DMA_CYCLE | REFRESH_CYCLE;

    // ==========================================================
    // Index / data port pair; the index stays put so a read-modify-write
    // needs only one index write
    assign data_sel = (IO_ADDR == PCM_DATA_PORT) && (index_reg == PCM_PWR_CFG_INDEX);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            index_reg <= PCM_INDEX_RESET;
        end else if (IO_WR && IO_ADDR == PCM_INDEX_PORT) begin
            index_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_reg <= PCM_PWR_CFG_RESET;
        end else if (IO_WR && data_sel) begin
            cfg_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= PCM_UNMAPPED_DATA;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= IO_RD && (IO_ADDR == PCM_DATA_PORT || IO_ADDR == PCM_INDEX_PORT);
            if (IO_RD && IO_ADDR == PCM_INDEX_PORT) begin
                rdata_reg <= index_reg;
            end else if (IO_RD && IO_ADDR == PCM_DATA_PORT) begin
                rdata_reg <= data_sel ? cfg_reg : PCM_UNMAPPED_DATA;
            end
        end
    end

    // ==========================================================
    // Sleep sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PCM_RUN: begin
                if (HALT_FETCH && cfg_reg[PCM_SLEEP_EN_BIT]) begin
                    state_next = PCM_SLEEP;
                end
            end
            PCM_SLEEP: begin
                // Clearing the enable also wakes, or the core could stay slow
                if (wake || !cfg_reg[PCM_SLEEP_EN_BIT]) begin
                    state_next = PCM_RUN;
                end else if (bus_busy) begin
                    state_next = PCM_SUSPEND;
                end
            end
            PCM_SUSPEND: begin
                if (wake || !cfg_reg[PCM_SLEEP_EN_BIT]) begin
                    state_next = PCM_RUN;
                end else if (!bus_busy) begin
                    state_next = PCM_SLEEP;
                end
            end
            default: begin
                state_next = PCM_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= PCM_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sleep_reg <= 1'b0;
        end else begin
            sleep_reg <= (state_next == PCM_SLEEP);
        end
    end

    // ==========================================================
    // Rate selection; minimum only when bits 1:0 request it
    assign sleep_shift = (cfg_reg[PCM_MIN_HI:PCM_MIN_LO] == PCM_MIN_SELECT) ?
                         SLEEP_SHIFT : PCM_SLOWEST_RUN_SHIFT;

    assign shift_req = (state_reg == PCM_SLEEP) ? sleep_shift :
                       {1'b0, cfg_reg[PCM_DIV_HI:PCM_DIV_LO]};
    assign dif.shift_req = shift_req;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PROC_CLK_EN <= 1'b0;
        end else begin
            PROC_CLK_EN <= dif.tick;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    assign IO_RDATA = rdata_reg;
    assign IO_RVALID = rvalid_reg;
    assign SLEEP_ACTIVE = sleep_reg;

    // ==========================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    property p_reset_state;
        first_reg |-> cfg_reg[PCM_DIV_HI:PCM_DIV_LO] == 2'h0 && !cfg_reg[PCM_SLEEP_EN_BIT];
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("divide or sleep enable not clear after reset");

    // Checks the rate the divider really adopted, not just the request
    property p_run_rate;
        dif.tick && state_reg == PCM_RUN && $past(state_reg) == PCM_RUN && $stable(cfg_reg)
            |-> dif.shift_cur == {1'b0, cfg_reg[PCM_DIV_HI:PCM_DIV_LO]};
    endproperty
    a_run_rate: assert property (p_run_rate)
        else $error("running rate does not follow divide field");

    sequence s_index_write;
        IO_WR && IO_ADDR == PCM_INDEX_PORT && IO_WDATA == PCM_PWR_CFG_INDEX;
    endsequence
    sequence s_data_write;
        IO_WR && IO_ADDR == PCM_DATA_PORT && !(IO_WR && IO_ADDR == PCM_INDEX_PORT);
    endsequence
    property p_index_data_write;
        s_index_write ##1 s_data_write |=> cfg_reg == $past(IO_WDATA);
    endproperty
    a_index_data_write: assert property (p_index_data_write)
        else $error("data port write did not update the register");

    property p_halt_enabled;
        state_reg == PCM_RUN && HALT_FETCH && cfg_reg[PCM_SLEEP_EN_BIT] |=>
            state_reg == PCM_SLEEP ##1 dif.shift_req == sleep_shift || !sleep_reg;
    endproperty
    a_halt_enabled: assert property (p_halt_enabled)
        else $error("HALT with sleep enabled did not enter sleep");

    property p_halt_disabled;
        state_reg == PCM_RUN && !cfg_reg[PCM_SLEEP_EN_BIT] |=> state_reg == PCM_RUN;
    endproperty
    a_halt_disabled: assert property (p_halt_disabled)
        else $error("sleep entered while disabled");

    property p_wake;
        state_reg != PCM_RUN && wake |=> state_reg == PCM_RUN && !SLEEP_ACTIVE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("interrupt did not end sleep");

    sequence s_suspend_window;
        state_reg == PCM_SLEEP && bus_busy && !wake && cfg_reg[PCM_SLEEP_EN_BIT];
    endsequence
    property p_suspend;
        s_suspend_window |=> state_reg == PCM_SUSPEND;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("DMA or refresh did not suspend sleep");

    property p_resume;
        state_reg == PCM_SUSPEND && !bus_busy && !wake && cfg_reg[PCM_SLEEP_EN_BIT]
            |=> state_reg == PCM_SLEEP;
    endproperty
    a_resume: assert property (p_resume)
        else $error("sleep not resumed after DMA or refresh");
endmodule : pcm_power_mgr

/* include/pcm_div_if.sv */
// Link between the sleep controller and the clock divider.
// Both ends run on the same clock.
`timescale 1ns/1ns
interface pcm_div_if;
    import pcm_pkg::*;
    logic [PCM_SHIFT_W-1:0] shift_req;
    logic [PCM_SHIFT_W-1:0] shift_cur;
    logic tick;
    modport ctrl (output shift_req, input shift_cur, input tick);
    modport div (input shift_req, output shift_cur, output tick);
endinterface : pcm_div_if

/* include/pcm_pkg.sv */
// Constants for the processor clock and power manager.
// Assumes an 8-bit I/O data path and 16-bit I/O addresses.
package pcm_pkg;
    // ==========================================================
    // I/O ports and register index
    localparam logic [15:0] PCM_INDEX_PORT = 16'h0022;
    localparam logic [15:0] PCM_DATA_PORT = 16'h0023;
    localparam logic [7:0] PCM_PWR_CFG_INDEX = 8'h46;
    // ==========================================================
    // Field layout of power_clock_config
    localparam int PCM_SLEEP_EN_BIT = 7;
    localparam int PCM_DIV_HI = 3;
    localparam int PCM_DIV_LO = 2;
    localparam int PCM_MIN_HI = 1;
    localparam int PCM_MIN_LO = 0;
    localparam logic [1:0] PCM_MIN_SELECT = 2'h3;
    localparam logic [7:0] PCM_PWR_CFG_RESET = 8'h00;
    localparam logic [7:0] PCM_INDEX_RESET = 8'h00;
    localparam logic [7:0] PCM_UNMAPPED_DATA = 8'h00;
    // ==========================================================
    // Divider: divide ratio is 2**shift
    localparam int PCM_SHIFT_W = 3;
    localparam logic [2:0] PCM_SLEEP_SHIFT_DEF = 3'h6;
    localparam logic [2:0] PCM_SLOWEST_RUN_SHIFT = 3'h3;
    localparam int PCM_CNT_W = 7;
    // ==========================================================
    // Sleep sequencer, one-hot
    typedef enum logic [2:0] {
        PCM_RUN = 3'h1,
        PCM_SLEEP = 3'h2,
        PCM_SUSPEND = 3'h4
    } pcm_state_e;
endpackage : pcm_pkg

/* test/pcm_host_model.sv */
// Behavioural host core that runs on the divided clock enable.
// Assumes the enable and all core signals are timed on one shared clock.
`timescale 1ns/1ns
module pcm_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic halt_cmd,
    output logic halt_fetch,
    output logic [7:0] gap
);
    logic [7:0] cnt_reg;
    // ==========================================================
    // Opcode fetch
    // A halted core fetches nothing, so the pulse comes only on an enabled edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halt_fetch <= 1'b0;
        end else begin
            halt_fetch <= halt_cmd && clk_en && !halt_fetch;
        end
    end
    // ==========================================================
    // Spacing of core clock pulses, in cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 8'h00;
            gap <= 8'h00;
        end else if (clk_en) begin
            cnt_reg <= 8'h00;
            gap <= cnt_reg + 8'h01;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : pcm_host_model

/* test/test_processor_clock_power_manager.sv */
// Self-checking bench for the processor clock and power manager.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ns
module test_processor_clock_power_manager
    import pcm_pkg::*;
;
    localparam logic [2:0] SLEEP_SH = 3'h4;
    logic clk, rst_b, io_wr, io_rd, io_rvalid, halt_fetch, halt_cmd;
    logic maskable_interrupt_request, nmi, dma, refresh, proc_clk_en, sleep_active;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, clk_gap;
    int miscompares, n_compared;

    pcm_power_mgr #(.SLEEP_SHIFT(SLEEP_SH)) dut (.CLK(clk), .RST_B(rst_b), .IO_ADDR(io_addr),
        .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
        .IO_RVALID(io_rvalid), .HALT_FETCH(halt_fetch), .MASKABLE_INTERRUPT_REQUEST(maskable_interrupt_request),
        .NMI(nmi), .DMA_CYCLE(dma), .REFRESH_CYCLE(refresh), .PROC_CLK_EN(proc_clk_en),
        .SLEEP_ACTIVE(sleep_active));
    pcm_host_model host (.clk(clk), .rst_b(rst_b), .clk_en(proc_clk_en),
        .halt_cmd(halt_cmd), .halt_fetch(halt_fetch), .gap(clk_gap));

    // ==========================================================
    // Compare and bus tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: flag %h expected %h", $time, got, exp);
        end
    endtask : check1
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask : io_write
    // Index then data with the strobe held high; back to back is legal
    task automatic io_write_pair(input logic [7:0] d);
        @(negedge clk);
        io_addr = PCM_INDEX_PORT;
        io_wdata = PCM_PWR_CFG_INDEX;
        io_wr = 1'b1;
        @(negedge clk);
        io_addr = PCM_DATA_PORT;
        io_wdata = d;
        @(negedge clk);
        io_wr = 1'b0;
    endtask : io_write_pair
    function automatic logic [7:0] exp_ratio(input logic [7:0] c, input logic asleep);
        if (asleep) begin
            return (c[PCM_MIN_HI:PCM_MIN_LO] == PCM_MIN_SELECT) ? 8'(1 << SLEEP_SH) : 8'h08;
        end
        return 8'(1 << c[PCM_DIV_HI:PCM_DIV_LO]);
    endfunction : exp_ratio
    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        check1(io_rvalid, 1'b1);
        d = io_rdata;
    endtask : io_read
    // Old rate may run one full period before the new one is adopted
    task automatic check_gap(input logic [7:0] ratio);
        repeat (2 * ratio + 20) @(negedge clk);
        check8(clk_gap, ratio);
    endtask : check_gap
    task automatic halt_core();
        int t;
        @(negedge clk);
        halt_cmd = 1'b1;
        for (t = 0; t < 40 && halt_fetch !== 1'b1; t++) @(negedge clk);
        halt_cmd = 1'b0;
        @(negedge clk);
    endtask : halt_core
    task automatic report_and_stop();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin : main
        logic [7:0] v, base, cfg;
        int k;
        {rst_b, io_wr, io_rd, halt_cmd, maskable_interrupt_request, nmi, dma, refresh} = 8'h00;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        miscompares = 0;
        n_compared = 0;
        k = $urandom(71);
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        io_write(PCM_INDEX_PORT, PCM_PWR_CFG_INDEX);
        io_read(PCM_DATA_PORT, v);
        check8(v, PCM_PWR_CFG_RESET);
        check_gap(8'h01);
        $display("test reset values done");
        for (k = 0; k < 4; k++) begin
            base = 8'($urandom) & 8'h73;
            io_write(PCM_DATA_PORT, base);
            io_read(PCM_DATA_PORT, v);
            check8(v, base);
            cfg = (base & 8'hf3) | 8'(k << 2);
            io_write(PCM_DATA_PORT, cfg);
            io_read(PCM_DATA_PORT, v);
            check8(v, cfg);
            check_gap(exp_ratio(cfg, 1'b0));
        end
        $display("test divide settings done");
        io_write(PCM_INDEX_PORT, 8'h47);
        io_read(PCM_INDEX_PORT, v);
        check8(v, 8'h47);
        io_write(PCM_DATA_PORT, 8'hff);
        io_read(PCM_DATA_PORT, v);
        check8(v, 8'h00);
        io_write(PCM_INDEX_PORT, PCM_PWR_CFG_INDEX);
        io_read(PCM_DATA_PORT, v);
        check8(v, cfg);
        halt_core();
        check1(sleep_active, 1'b0);
        check_gap(exp_ratio(cfg, 1'b0));
        $display("test index and halt without sleep done");
        cfg = cfg | 8'h83;
        io_write_pair(cfg);
        halt_core();
        check1(sleep_active, 1'b1);
        check_gap(exp_ratio(cfg, 1'b1));
        for (k = 0; k < 2; k++) begin
            @(negedge clk);
            dma = (k == 0);
            refresh = (k == 1);
            repeat (3) @(negedge clk);
            check1(sleep_active, 1'b0);
            {dma, refresh} = 2'h0;
            repeat (3) @(negedge clk);
            check1(sleep_active, 1'b1);
        end
        $display("test sleep and suspend done");
        for (k = 0; k < 2; k++) begin
            if (k == 1) halt_core();
            check1(sleep_active, 1'b1);
            @(negedge clk);
            maskable_interrupt_request = (k == 0);
            nmi = (k == 1);
            repeat (8) @(negedge clk);
            check1(sleep_active, 1'b0);
            {maskable_interrupt_request, nmi} = 2'h0;
            check_gap(exp_ratio(cfg, 1'b0));
        end
        $display("test wake sources done");
        halt_core();
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        check1(sleep_active, 1'b0);
        rst_b = 1'b1;
        io_write(PCM_INDEX_PORT, PCM_PWR_CFG_INDEX);
        io_read(PCM_DATA_PORT, v);
        check8(v, PCM_PWR_CFG_RESET);
        halt_core();
        check1(sleep_active, 1'b0);
        check_gap(8'h01);
        $display("test reset in sleep done");
        report_and_stop();
    end
endmodule : test_processor_clock_power_manager
